// file: common/tws_defs.vh
// Purpose: constants for the two-wire slave receiver block
// Assumes: included by bare name from the design files
// Notes:   register indices are word offsets on the plain register port
// Functional notes
// - respond only when upper seven address bits match
// - address lsb one enables general call 0x00
// - direction zero receives, one selects transmitter
// - own write address acked sets flag, status
// - prescaler bits of status read as zero
// - lost arbitration then addressed reports 0x68/0x78
// - ack enable cleared gives nack next byte
// - ack enable zero ignores address, still monitors
// - deep sleep match wakes part, holds clock
// - data register not updated while asleep
// - own write address acked reports 0x60
// - general call acked reports 0x70
// - own data byte acked reports 0x80
// - flag clear receives next byte per ack
// - 0x88 with ack zero: no recognition
// - 0x88 means own data byte nacked
// - 0x88 with ack one keeps recognition, start
// - stop or restart while addressed reports 0xA0
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH

`define TWS_OFF_OWN_ADDR   3'h0
`define TWS_OFF_CTRL       3'h1
`define TWS_OFF_STATUS     3'h2
`define TWS_OFF_DATA       3'h3

`define TWS_CTRL_FLAG      7
`define TWS_CTRL_ACK_EN    6
`define TWS_CTRL_START     5
`define TWS_CTRL_STOP      4
`define TWS_CTRL_WCOL      3
`define TWS_CTRL_ENABLE    2
`define TWS_CTRL_IRQ_EN    0

`define TWS_RST_OWN_ADDR   8'h00
`define TWS_RST_DATA       8'hff
`define TWS_RST_STATUS     8'hf8

`define TWS_ST_OWN_ACK     8'h60
`define TWS_ST_ARB_OWN     8'h68
`define TWS_ST_GC_ACK      8'h70
`define TWS_ST_ARB_GC      8'h78
`define TWS_ST_OWN_DATA    8'h80
`define TWS_ST_OWN_NACK    8'h88
`define TWS_ST_GC_DATA     8'h90
`define TWS_ST_GC_NACK     8'h98
`define TWS_ST_STOP_RX     8'ha0

`define TWS_GC_ADDR        8'h00
`define TWS_BITS_PER_BYTE  4'h8

`endif

// file: logic/tws_sync.v
// Purpose: two-flop synchroniser for pins from outside the core clock
// Assumes: reset value is the idle level of the sampled lines
// Notes:   only the second stage may be read by other logic
`timescale 1ns/10ps
module tws_sync #(
    parameter W       = 2,
    parameter RST_VAL = 2'b11
) (
    input  wire         clk,
    input  wire         rst_b,
    input  wire         ce,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge clk) begin
        if (!rst_b) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else if (ce) begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule

// file: logic/tws_slave_rx.v
// Purpose: slave receiver of a byte-oriented two-wire serial interface
// Assumes: bus pins are open drain, sampled by CORE_CLK well above SCL
// Notes:   slave transmitter is not built here; a read address is only
//          flagged on TX_MODE_REQ for the neighbouring logic
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "tws_defs.vh"
module tws_slave_rx (
    input  wire       CORE_CLK,
    input  wire       RST_B,
    input  wire       CLK_EN,
    input  wire [2:0] REG_ADDR,
    input  wire [7:0] REG_WDATA,
    input  wire       REG_WR,
    input  wire       REG_RD,
    output wire [7:0] REG_RDATA,
    input  wire       SCL_IN,
    output wire       SCL_OUT,
    output wire       SCL_OE,
    input  wire       SDA_IN,
    output wire       SDA_OUT,
    output wire       SDA_OE,
    input  wire       SLEEP_ACTIVE,
    input  wire       ARB_LOST_ADDR,
    output wire       JOB_DONE,
    output wire       WAKE_REQ,
    output wire       TX_MODE_REQ,
    output wire       START_PENDING
);
    localparam ST_IDLE   = 3'd0;
    localparam ST_ADDR   = 3'd1;
    localparam ST_DATA   = 3'd2;
    localparam ST_ACK    = 3'd3;
    localparam ST_IGNORE = 3'd4;

    wire       scl_s;
    wire       sda_s;
    reg        scl_d_ff;
    reg        sda_d_ff;

    reg  [2:0] state_ff;
    reg  [2:0] nxt_state;
    reg  [3:0] cnt_ff;
    reg  [3:0] nxt_cnt;
    reg  [7:0] shift_ff;
    reg  [7:0] nxt_shift;
    reg  [7:0] pend_ff;
    reg  [7:0] nxt_pend;
    reg        nack_ff;
    reg        nxt_nack;
    reg        sda_drv_ff;
    reg        nxt_sda_drv;
    reg        own_sel_ff;
    reg        nxt_own_sel;
    reg        gc_sel_ff;
    reg        nxt_gc_sel;
    reg        arb_ff;
    reg        nxt_arb;
    reg        busy_ff;
    reg        nxt_busy;
    reg        wake_ff;
    reg        nxt_wake;
    reg        tx_req_ff;
    reg        nxt_tx_req;

    reg  [7:0] status_ff;
    reg  [7:0] nxt_status;
    reg        flag_ff;
    reg        nxt_flag;
    reg        hold_ff;
    reg        nxt_hold;
    reg  [7:0] data_ff;
    reg  [7:0] nxt_data;
    reg  [7:0] own_addr_ff;
    reg        ack_en_ff;
    reg        start_req_ff;
    reg        stop_req_ff;
    reg        enable_ff;
    reg        irq_en_ff;
    reg  [7:0] rdata_ff;
    reg  [7:0] nxt_rdata;

    reg        set_ev;
    reg  [7:0] set_code;
    reg        set_hold;
    reg        load_rx;
    reg  [7:0] ctrl_view;

    wire       addressed;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_ev;
    wire       stop_ev;
    wire       addr_eq;
    wire       own_hit;
    wire       gc_hit;
    wire       tx_hit;
    wire       wr_ctrl;
    wire       flag_clr;

    tws_sync #(
        .W       (2),
        .RST_VAL (2'b11)
    ) u_sync (
        .clk   (CORE_CLK),
        .rst_b (RST_B),
        .ce    (CLK_EN),
        .d     ({SCL_IN, SDA_IN}),
        .q     ({scl_s, sda_s})
    );

    // edges are taken from the synchronised lines only
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    assign start_ev = scl_s & scl_d_ff & ~sda_s & sda_d_ff;
    assign stop_ev  = scl_s & scl_d_ff & sda_s & ~sda_d_ff;

    assign addressed = own_sel_ff | gc_sel_ff;
    assign addr_eq   = (shift_ff[7:1] == own_addr_ff[7:1]);
    assign gc_hit    = (shift_ff == `TWS_GC_ADDR) & own_addr_ff[0];
    assign own_hit   = addr_eq & ~shift_ff[0] & (shift_ff[7:1] != 7'h00);
    assign tx_hit    = addr_eq & shift_ff[0];

    assign wr_ctrl  = REG_WR & (REG_ADDR == `TWS_OFF_CTRL);
    assign flag_clr = wr_ctrl & REG_WDATA[`TWS_CTRL_FLAG];

    // bus-side sequencer
    always @* begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_shift   = shift_ff;
        nxt_pend    = pend_ff;
        nxt_nack    = nack_ff;
        nxt_sda_drv = sda_drv_ff;
        nxt_own_sel = own_sel_ff;
        nxt_gc_sel  = gc_sel_ff;
        nxt_arb     = arb_ff | ARB_LOST_ADDR;
        nxt_busy    = busy_ff;
        nxt_wake    = wake_ff & ~flag_clr;
        nxt_tx_req  = 1'b0;
        set_ev      = 1'b0;
        set_code    = status_ff;
        set_hold    = 1'b0;
        load_rx     = 1'b0;
        if (!enable_ff) begin
            nxt_state   = ST_IDLE;
            nxt_cnt     = 4'h0;
            nxt_sda_drv = 1'b0;
            nxt_own_sel = 1'b0;
            nxt_gc_sel  = 1'b0;
            nxt_busy    = 1'b0;
        end else if (start_ev) begin
            if (addressed) begin
                set_ev   = 1'b1;
                set_code = `TWS_ST_STOP_RX;
            end
            nxt_own_sel = 1'b0;
            nxt_gc_sel  = 1'b0;
            nxt_sda_drv = 1'b0;
            nxt_state   = ST_ADDR;
            nxt_cnt     = 4'h0;
            nxt_busy    = 1'b1;
        end else if (stop_ev) begin
            if (addressed) begin
                set_ev   = 1'b1;
                set_code = `TWS_ST_STOP_RX;
            end
            nxt_own_sel = 1'b0;
            nxt_gc_sel  = 1'b0;
            nxt_sda_drv = 1'b0;
            nxt_state   = ST_IDLE;
            nxt_busy    = 1'b0;
            nxt_arb     = 1'b0;
        end else if (scl_rise && cnt_ff != `TWS_BITS_PER_BYTE &&
                     (state_ff == ST_ADDR || state_ff == ST_DATA)) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_cnt   = cnt_ff + 4'h1;
        end else if (scl_fall && state_ff == ST_ADDR &&
                     cnt_ff == `TWS_BITS_PER_BYTE) begin
            nxt_cnt = 4'h0;
            // ack enable low leaves the bus watched but unanswered
            if (ack_en_ff && (own_hit || gc_hit)) begin
                nxt_state   = ST_ACK;
                nxt_sda_drv = 1'b1;
                nxt_nack    = 1'b0;
                nxt_own_sel = own_hit;
                nxt_gc_sel  = ~own_hit;
                nxt_arb     = 1'b0;
                nxt_wake    = SLEEP_ACTIVE;
                if (own_hit)
                    nxt_pend = arb_ff ? `TWS_ST_ARB_OWN
                                      : `TWS_ST_OWN_ACK;
                else
                    nxt_pend = arb_ff ? `TWS_ST_ARB_GC
                                      : `TWS_ST_GC_ACK;
            end else begin
                nxt_tx_req = ack_en_ff & tx_hit;
                nxt_state  = ST_IGNORE;
            end
        end else if (scl_fall && state_ff == ST_DATA &&
                     cnt_ff == `TWS_BITS_PER_BYTE) begin
            nxt_cnt     = 4'h0;
            nxt_state   = ST_ACK;
            nxt_sda_drv = ack_en_ff;
            nxt_nack    = ~ack_en_ff;
            load_rx     = ~SLEEP_ACTIVE;
            if (own_sel_ff)
                nxt_pend = ack_en_ff ? `TWS_ST_OWN_DATA
                                     : `TWS_ST_OWN_NACK;
            else
                nxt_pend = ack_en_ff ? `TWS_ST_GC_DATA
                                     : `TWS_ST_GC_NACK;
        end else if (scl_fall && state_ff == ST_ACK) begin
            nxt_sda_drv = 1'b0;
            set_ev      = 1'b1;
            set_code    = pend_ff;
            set_hold    = 1'b1;
            if (nack_ff) begin
                // refused byte: not addressed, recognition follows ack
                nxt_state   = ST_IGNORE;
                nxt_own_sel = 1'b0;
                nxt_gc_sel  = 1'b0;
            end else begin
                nxt_state = ST_DATA;
            end
        end
    end

    // flag, status and data storage; a new event beats a clear
    always @* begin
        nxt_flag   = set_ev | (flag_ff & ~flag_clr);
        nxt_status = set_ev ? set_code : status_ff;
        nxt_hold   = set_ev ? set_hold : (hold_ff & ~flag_clr);
        nxt_data   = data_ff;
        if (load_rx)
            nxt_data = shift_ff;
        else if (REG_WR && REG_ADDR == `TWS_OFF_DATA)
            nxt_data = REG_WDATA;
    end

    always @* begin
        ctrl_view = 8'h00;
        ctrl_view[`TWS_CTRL_FLAG]   = flag_ff;
        ctrl_view[`TWS_CTRL_ACK_EN] = ack_en_ff;
        ctrl_view[`TWS_CTRL_START]  = start_req_ff;
        ctrl_view[`TWS_CTRL_STOP]   = stop_req_ff;
        ctrl_view[`TWS_CTRL_ENABLE] = enable_ff;
        ctrl_view[`TWS_CTRL_IRQ_EN] = irq_en_ff;
        nxt_rdata = 8'h00;
        if (REG_RD) begin
            case (REG_ADDR)
                `TWS_OFF_OWN_ADDR: nxt_rdata = own_addr_ff;
                `TWS_OFF_CTRL:     nxt_rdata = ctrl_view;
                `TWS_OFF_STATUS:   nxt_rdata = {status_ff[7:3], 3'h0};
                `TWS_OFF_DATA:     nxt_rdata = data_ff;
                default:           nxt_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge CORE_CLK) begin
        if (!RST_B) begin
            scl_d_ff     <= 1'b1;
            sda_d_ff     <= 1'b1;
            state_ff     <= ST_IDLE;
            cnt_ff       <= 4'h0;
            shift_ff     <= 8'h00;
            pend_ff      <= 8'h00;
            nack_ff      <= 1'b0;
            sda_drv_ff   <= 1'b0;
            own_sel_ff   <= 1'b0;
            gc_sel_ff    <= 1'b0;
            arb_ff       <= 1'b0;
            busy_ff      <= 1'b0;
            wake_ff      <= 1'b0;
            tx_req_ff    <= 1'b0;
            status_ff    <= `TWS_RST_STATUS;
            flag_ff      <= 1'b0;
            hold_ff      <= 1'b0;
            data_ff      <= `TWS_RST_DATA;
            own_addr_ff  <= `TWS_RST_OWN_ADDR;
            ack_en_ff    <= 1'b0;
            start_req_ff <= 1'b0;
            stop_req_ff  <= 1'b0;
            enable_ff    <= 1'b0;
            irq_en_ff    <= 1'b0;
            rdata_ff     <= 8'h00;
        end else if (CLK_EN) begin
            scl_d_ff   <= scl_s;
            sda_d_ff   <= sda_s;
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            shift_ff   <= nxt_shift;
            pend_ff    <= nxt_pend;
            nack_ff    <= nxt_nack;
            sda_drv_ff <= nxt_sda_drv;
            own_sel_ff <= nxt_own_sel;
            gc_sel_ff  <= nxt_gc_sel;
            arb_ff     <= nxt_arb;
            busy_ff    <= nxt_busy;
            wake_ff    <= nxt_wake;
            tx_req_ff  <= nxt_tx_req;
            status_ff  <= nxt_status;
            flag_ff    <= nxt_flag;
            hold_ff    <= nxt_hold;
            data_ff    <= nxt_data;
            rdata_ff   <= nxt_rdata;
            if (REG_WR && REG_ADDR == `TWS_OFF_OWN_ADDR)
                own_addr_ff <= REG_WDATA;
            if (wr_ctrl) begin
                ack_en_ff    <= REG_WDATA[`TWS_CTRL_ACK_EN];
                start_req_ff <= REG_WDATA[`TWS_CTRL_START];
                stop_req_ff  <= REG_WDATA[`TWS_CTRL_STOP];
                enable_ff    <= REG_WDATA[`TWS_CTRL_ENABLE];
                irq_en_ff    <= REG_WDATA[`TWS_CTRL_IRQ_EN];
            end
        end
    end

    // open drain: only ever pull low; a long wake-up keeps SCL low long
    assign SCL_OUT       = 1'b0;
    assign SDA_OUT       = 1'b0;
    assign SCL_OE        = flag_ff & hold_ff;
    assign SDA_OE        = sda_drv_ff;
    assign REG_RDATA     = rdata_ff;
    assign JOB_DONE      = flag_ff;
    assign WAKE_REQ      = wake_ff;
    assign TX_MODE_REQ   = tx_req_ff;
    // start is handed to the master path once the bus is free
    assign START_PENDING = enable_ff & start_req_ff & ~flag_ff &
                           ~busy_ff;
endmodule

// file: sim/tws_master_model.sv
// Purpose: two-wire bus master that writes bytes to the slave
// Assumes: bench resolves open-drain levels with pull-ups
// Notes:   holds SCL low itself after every byte; rise waits on a stretch
`timescale 1ns/10ps
module tws_master_model (
    input  wire       scl,
    input  wire       sda,
    output reg        scl_low,
    output reg        sda_low,
    output reg  [7:0] n_stuck
);
    localparam int HALF = 80;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        n_stuck = 8'h00;
    end
    // a slave may stretch; bounded so a stuck line cannot hang the run
    task automatic rise();
        scl_low = 1'b0;
        for (int i = 0; i < 2000 && scl !== 1'b1; i++) #10;
        if (scl !== 1'b1) n_stuck++;
    endtask
    task automatic start();
        sda_low = 1'b0;
        #HALF rise();
        #HALF sda_low = 1'b1;
        #HALF scl_low = 1'b1;
        #HALF;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        #HALF rise();
        #HALF sda_low = 1'b0;
        #HALF;
    endtask
    // ninth pass releases SDA and samples the answer
    task automatic send(input logic [7:0] d, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_low = (i > 0) ? !d[i-1] : 1'b0;
            #HALF rise();
            ack = !sda;
            #HALF scl_low = 1'b1;
            #20;
        end
        #(2 * HALF);
    endtask
endmodule

// file: sim/tws_slave_rx_asserts.sv
// Purpose: port checks for the slave receiver
// Assumes: one clock domain, CLK_EN dropped only while the bus is idle
// Notes:   ack enable is mirrored from control writes
`timescale 1ns/10ps
module tws_slave_rx_chk (
    input wire       CORE_CLK,
    input wire       RST_B,
    input wire [2:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire       REG_WR,
    input wire       REG_RD,
    input wire [7:0] REG_RDATA,
    input wire       SCL_OE,
    input wire       SDA_OE,
    input wire       SLEEP_ACTIVE,
    input wire       JOB_DONE,
    input wire       WAKE_REQ,
    input wire       TX_MODE_REQ
);
    reg  ack_en_ff;
    wire ctl_wr = REG_WR && REG_ADDR == 3'h1;
    always @(posedge CORE_CLK) begin
        if (!RST_B) ack_en_ff <= 1'b0;
        else if (ctl_wr) ack_en_ff <= REG_WDATA[6];
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_ack; SDA_OE [*4] ##[1:20] !SDA_OE; endsequence
    property p_ack_len; $rose(SDA_OE) |-> s_ack; endproperty
    a_ack_len: assert property (p_ack_len) else $error("bad ack");
    property p_ack_en; $rose(SDA_OE) |-> ack_en_ff; endproperty
    a_ack_en: assert property (p_ack_en) else $error("ack off");
    property p_status;
        $past(REG_RD) && $past(REG_ADDR) == 3'h2 |-> REG_RDATA[2:0] == 3'h0;
    endproperty
    a_status: assert property (p_status) else $error("status low");
    property p_hold; SCL_OE |-> JOB_DONE; endproperty
    a_hold: assert property (p_hold) else $error("stray hold");
    // once stretching, only a flag-clear write may let SCL go
    property p_keep;
        SCL_OE && !(ctl_wr && REG_WDATA[7]) |=> SCL_OE;
    endproperty
    a_keep: assert property (p_keep) else $error("hold dropped");
    property p_rel; $fell(JOB_DONE) |-> ##[0:1] !SCL_OE; endproperty
    a_rel: assert property (p_rel) else $error("no release");
    property p_clr;
        ctl_wr && REG_WDATA[7] && JOB_DONE && SCL_OE |=> !JOB_DONE;
    endproperty
    a_clr: assert property (p_clr) else $error("no clear");
    property p_excl; !(SDA_OE && SCL_OE); endproperty
    a_excl: assert property (p_excl) else $error("ack in hold");
    property p_wake;
        $rose(WAKE_REQ) |-> SLEEP_ACTIVE || $past(SLEEP_ACTIVE);
    endproperty
    a_wake: assert property (p_wake) else $error("awake wake");
    property p_tx; TX_MODE_REQ |=> !TX_MODE_REQ; endproperty
    a_tx: assert property (p_tx) else $error("long tx pulse");
endmodule
bind tws_slave_rx tws_slave_rx_chk chk_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SCL_OE(SCL_OE),
    .SDA_OE(SDA_OE), .SLEEP_ACTIVE(SLEEP_ACTIVE), .JOB_DONE(JOB_DONE),
    .WAKE_REQ(WAKE_REQ), .TX_MODE_REQ(TX_MODE_REQ));

// file: sim/tws_slave_rx_tb.sv
// Purpose: self-checking bench for the slave receiver
// Assumes: master model drives the bus, pull-ups on SCL and SDA
// Notes:   CLK_EN is dropped only while the bus is idle
`timescale 1ns/10ps
module tws_slave_rx_tb;
    logic       CORE_CLK = 1'b0, RST_B = 1'b0, tx_seen = 1'b0;
    logic       REG_WR = 1'b0, REG_RD = 1'b0, CLK_EN = 1'b1;
    logic       SLEEP_ACTIVE = 1'b0, ARB_LOST_ADDR = 1'b0;
    logic [2:0] REG_ADDR = 3'h0;
    logic [7:0] REG_WDATA = 8'h00;
    wire  [7:0] REG_RDATA, n_stuck;
    wire        SCL_OE, SDA_OE, JOB_DONE, WAKE_REQ, TX_MODE_REQ;
    wire        START_PENDING, SCL_OUT, SDA_OUT;
    wire        scl_low, sda_low;
    int         failures = 0, n_compared = 0;
    // open drain: a line is high unless some party pulls it low
    wire        scl_bus = !(scl_low || SCL_OE);
    wire        sda_bus = !(sda_low || SDA_OE);
    always #10 CORE_CLK = !CORE_CLK;
    always @(posedge CORE_CLK) if (TX_MODE_REQ === 1'b1) tx_seen <= 1'b1;
    tws_slave_rx dut_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SCL_IN(scl_bus),
        .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(sda_bus),
        .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SLEEP_ACTIVE(SLEEP_ACTIVE),
        .ARB_LOST_ADDR(ARB_LOST_ADDR), .JOB_DONE(JOB_DONE),
        .WAKE_REQ(WAKE_REQ), .TX_MODE_REQ(TX_MODE_REQ),
        .START_PENDING(START_PENDING));
    tws_master_model m_u (.scl(scl_bus), .sda(sda_bus), .scl_low(scl_low),
        .sda_low(sda_low), .n_stuck(n_stuck));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1 chk(REG_RDATA, exp);
    endtask
    // waits for the flag, then reads the status code
    task automatic flag(input logic [7:0] st);
        for (int i = 0; i < 100 && JOB_DONE !== 1'b1; i++) @(posedge CORE_CLK);
        if (JOB_DONE !== 1'b1) begin
            failures++;
            print_verdict();
        end else begin
            chk_rd(3'h2, st);
        end
    endtask
    // exp holds the expected acknowledge and flag, in that order
    task automatic snd(input logic [7:0] d, input logic [1:0] exp);
        logic ack;
        m_u.send(d, ack);
        chk({6'h00, ack, JOB_DONE}, {6'h00, exp});
    endtask
    task automatic addressed(input logic [7:0] a, input logic [7:0] st);
        m_u.start();
        snd(a, 2'b11);
        flag(st);
        chk({6'h00, SCL_OE, WAKE_REQ}, {7'h01, SLEEP_ACTIVE});
        wr(3'h1, 8'hc4);
        m_u.stop();
        flag(8'ha0);
        wr(3'h1, 8'hc4);
    endtask
    task automatic t_reset();
        chk_rd(3'h2, 8'hf8);
        chk_rd(3'h3, 8'hff);
        chk_rd(3'h0, 8'h00);
        wr(3'h2, 8'h00);
        wr(3'h6, 8'h5a);
        chk_rd(3'h2, 8'hf8);
        chk_rd(3'h6, 8'h00);
    endtask
    task automatic t_own();
        wr(3'h0, 8'ha5);
        wr(3'h1, 8'h44);
        m_u.start();
        snd(8'ha6, 2'b00);
        m_u.start();
        snd(8'ha5, 2'b00);
        chk({7'h00, tx_seen}, 8'h01);
        m_u.start();
        snd(8'ha4, 2'b11);
        flag(8'h60);
        wr(3'h1, 8'hc4);
        snd(8'h96, 2'b11);
        flag(8'h80);
        chk_rd(3'h3, 8'h96);
        wr(3'h1, 8'h84);
        snd(8'h5a, 2'b01);
        flag(8'h88);
        wr(3'h1, 8'h84);
        snd(8'h11, 2'b00);
        m_u.start();
        snd(8'ha4, 2'b00);
        wr(3'h1, 8'h44);
        addressed(8'ha4, 8'h60);
    endtask
    // byte on the bus, lost-arbitration and sleep flags, expected status
    task automatic t_table();
        logic [19:0] tbl [4] = '{20'ha4160, 20'h00070, 20'ha4268, 20'h00278};
        for (int k = 0; k < 4; k++) begin
            @(posedge CORE_CLK);
            SLEEP_ACTIVE <= tbl[k][8];
            ARB_LOST_ADDR <= tbl[k][9];
            @(posedge CORE_CLK);
            ARB_LOST_ADDR <= 1'b0;
            addressed(tbl[k][19:12], tbl[k][7:0]);
        end
    endtask
    task automatic t_no_gc();
        wr(3'h0, 8'ha4);
        m_u.start();
        snd(8'h00, 2'b00);
        m_u.stop();
    endtask
    // a write under a frozen clock enable is lost; start shows on an idle bus and drops when its bit clears
    task automatic t_misc();
        @(posedge CORE_CLK);
        CLK_EN <= 1'b0;
        wr(3'h0, 8'h3c);
        CLK_EN <= 1'b1;
        chk_rd(3'h0, 8'ha4);
        wr(3'h1, 8'h24);
        #1 chk({6'h00, START_PENDING, SCL_OUT | SDA_OUT}, 8'h02);
        wr(3'h1, 8'h04);
        #1 chk({7'h00, START_PENDING}, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge CORE_CLK);
        RST_B <= 1'b1;
        t_reset();
        t_own();
        t_table();
        t_no_gc();
        t_misc();
        chk(n_stuck, 8'h00);
        print_verdict();
    end
endmodule
